// ---- rtl/capacity_warning_flags.sv ----
// capacity warning flags, event flags, scratch storage and power modes behind apb
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// [R1] set the low-charge warning when capacity drops below the early set level
// [R2] clear the low-charge warning only once capacity climbs above the early clear level
// [R3] set the final warning when capacity drops below the final set level
// [R4] a final set level of minus one never raises the final warning
// [R5] clear the final warning only when set and capacity rises above its clear level
// [R6] raise the internal short flag on a short found while the cell is relaxed
// [R7] raise the tab disconnect flag on a tab loss found in a parallel pack
// [R8] offer 64 bytes of user storage as two separately addressed 32-byte blocks
// [R9] move among power modes on events; host may request some modes
// [R10] host reads and writes control, status and storage; the block serves it
// [R11] host selects a storage location by block and byte offset
// [R12] all level comparisons use the incoming capacity value, on the edge that latches it, signed, strict
module capacity_warning_flags #(
  parameter int CAP_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CAP_W-1:0] capacity_in,
  input wire logic capacity_valid,
  input wire logic cell_relaxed,
  input wire logic short_detected,
  input wire logic tab_loss_detected,
  input wire logic cell_idle,
  output logic low_charge_warning_flag,
  output logic final_discharge_warning_flag,
  output logic internal_short_flag,
  output logic tab_disconnect_flag,
  output logic [3:0] power_mode,
  output logic irq
);
  // levels narrower than 2 bits or wider than 16 bits cannot be served
  if (CAP_W < 2 || CAP_W > 16)
  begin : g_chk
    $error("CAP_W must lie between 2 and 16");
  end

  localparam logic [CAP_W-1:0] MINUS_ONE = '1;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [CAP_W-1:0] capacity_r, ew_set_r, ew_clr_r, fw_set_r, fw_clr_r;
  logic low_r, low_nxt, final_r, final_nxt, short_r, tab_r;
  logic [1:0] config_r, req_r;
  logic [3:0] int_stat_r, int_mask_r, events;
  capacity_warning_pkg::power_mode_t mode_r, mode_nxt;
  logic [31:0] block_a [capacity_warning_pkg::BLOCK_WORDS];
  logic [31:0] block_b [capacity_warning_pkg::BLOCK_WORDS];
  logic wr_en, setup;
  logic [31:0] rd_nxt;
  logic hit;

  // signed strict compare shared by all four levels
  function automatic logic below(input logic [CAP_W-1:0] a, input logic [CAP_W-1:0] b);
    below = $signed(a) < $signed(b);
  endfunction : below

  // scratch address decode: whether an address falls in the given block
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
    in_block = a[7:5] == base[7:5];
  endfunction : in_block

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, read data captured in the setup cycle, write data in the access cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1; // [R10]

  // read mux and unmapped detect
  always_comb
  begin
    rd_nxt = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      capacity_warning_pkg::OFF_STATUS:
      begin
        rd_nxt[capacity_warning_pkg::BIT_LOW] = low_r;
        rd_nxt[capacity_warning_pkg::BIT_FINAL] = final_r;
        rd_nxt[capacity_warning_pkg::BIT_SHORT] = short_r;
        rd_nxt[capacity_warning_pkg::BIT_TAB] = tab_r;
        rd_nxt[capacity_warning_pkg::BIT_MODE_LSB +: 4] = mode_r;
      end
      capacity_warning_pkg::OFF_CAPACITY: rd_nxt[CAP_W-1:0] = capacity_r;
      capacity_warning_pkg::OFF_EW_SET: rd_nxt[CAP_W-1:0] = ew_set_r;
      capacity_warning_pkg::OFF_EW_CLR: rd_nxt[CAP_W-1:0] = ew_clr_r;
      capacity_warning_pkg::OFF_FW_SET: rd_nxt[CAP_W-1:0] = fw_set_r;
      capacity_warning_pkg::OFF_FW_CLR: rd_nxt[CAP_W-1:0] = fw_clr_r;
      capacity_warning_pkg::OFF_CONFIG: rd_nxt[1:0] = config_r;
      capacity_warning_pkg::OFF_MODE_REQ: rd_nxt[1:0] = req_r;
      capacity_warning_pkg::OFF_INT_STAT: rd_nxt[3:0] = int_stat_r;
      capacity_warning_pkg::OFF_INT_MASK: rd_nxt[3:0] = int_mask_r;
      default:
      begin
        // word select inside a block, block picked by address bit 5
        if (in_block(paddr, capacity_warning_pkg::OFF_BLOCK_A) && paddr[1:0] == 2'h0)
          rd_nxt = block_a[paddr[4:2]]; // [R11]
        else if (in_block(paddr, capacity_warning_pkg::OFF_BLOCK_B) && paddr[1:0] == 2'h0)
          rd_nxt = block_b[paddr[4:2]]; // [R11]
        else
          hit = 1'b0;
      end
    endcase
  end

  // read data and error held from setup through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h00000000 : rd_nxt; // [R10]
      pslverr <= !hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // programmable levels and config; a write to an unmapped word does nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ew_set_r <= capacity_warning_pkg::RST_EW_SET[CAP_W-1:0];
      ew_clr_r <= capacity_warning_pkg::RST_EW_CLR[CAP_W-1:0];
      fw_set_r <= capacity_warning_pkg::RST_FW_SET[CAP_W-1:0];
      fw_clr_r <= capacity_warning_pkg::RST_FW_CLR[CAP_W-1:0];
      config_r <= capacity_warning_pkg::RST_CONFIG;
      int_mask_r <= capacity_warning_pkg::RST_INT_MASK;
    end
    else if (wr_en)
    begin
      case (paddr)
        capacity_warning_pkg::OFF_EW_SET: ew_set_r <= pwdata[CAP_W-1:0]; // [R10]
        capacity_warning_pkg::OFF_EW_CLR: ew_clr_r <= pwdata[CAP_W-1:0];
        capacity_warning_pkg::OFF_FW_SET: fw_set_r <= pwdata[CAP_W-1:0];
        capacity_warning_pkg::OFF_FW_CLR: fw_clr_r <= pwdata[CAP_W-1:0];
        capacity_warning_pkg::OFF_CONFIG: config_r <= pwdata[1:0];
        capacity_warning_pkg::OFF_INT_MASK: int_mask_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // user storage; not reset, it stands for nonvolatile memory
  always_ff @(posedge pclk)
  begin
    if (wr_en && paddr[1:0] == 2'h0)
    begin
      if (in_block(paddr, capacity_warning_pkg::OFF_BLOCK_A))
        block_a[paddr[4:2]] <= pwdata; // [R8]
      if (in_block(paddr, capacity_warning_pkg::OFF_BLOCK_B))
        block_b[paddr[4:2]] <= pwdata; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hysteresis flags judged against the incoming value, same edge as the latch
  always_comb
  begin
    low_nxt = low_r;
    final_nxt = final_r;
    if (capacity_valid)
    begin
      // set outranks clear if the levels are programmed inverted
      if (below(capacity_in, ew_set_r)) // [R1] [R12]
        low_nxt = 1'b1;
      else if (below(ew_clr_r, capacity_in)) // [R2] [R12]
        low_nxt = 1'b0;
      if (fw_set_r != MINUS_ONE && below(capacity_in, fw_set_r)) // [R3] [R4]
        final_nxt = 1'b1;
      else if (final_r && below(fw_clr_r, capacity_in)) // [R5] [R12]
        final_nxt = 1'b0;
    end
  end

  // capacity latch and warning flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capacity_r <= '0;
      low_r <= 1'b0;
      final_r <= 1'b0;
    end
    else
    begin
      if (capacity_valid)
        capacity_r <= capacity_in; // [R12]
      low_r <= low_nxt;
      final_r <= final_nxt;
    end
  end

  // condition flags: sticky, write one to the status bit clears, detection wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      short_r <= 1'b0;
      tab_r <= 1'b0;
    end
    else
    begin
      if (cell_relaxed && short_detected)
        short_r <= 1'b1; // [R6]
      else if (wr_en && paddr == capacity_warning_pkg::OFF_STATUS
               && pwdata[capacity_warning_pkg::BIT_SHORT])
        short_r <= 1'b0;
      if (config_r[capacity_warning_pkg::BIT_PARALLEL] && tab_loss_detected)
        tab_r <= 1'b1; // [R7]
      else if (wr_en && paddr == capacity_warning_pkg::OFF_STATUS
               && pwdata[capacity_warning_pkg::BIT_TAB])
        tab_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt: rising flags are events; set beats write-one-to-clear
  logic low_q, final_q, short_q, tab_q;
  assign events = {tab_r, short_r, final_r, low_r} == 4'h0 ? 4'h0 :
    {tab_r, short_r, final_r, low_r} & ~{tab_q, short_q, final_q, low_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tab_q, short_q, final_q, low_q} <= 4'h0;
      int_stat_r <= 4'h0;
    end
    else
    begin
      {tab_q, short_q, final_q, low_q} <= {tab_r, short_r, final_r, low_r};
      if (wr_en && paddr == capacity_warning_pkg::OFF_INT_STAT)
        int_stat_r <= (int_stat_r & ~pwdata[3:0]) | events;
      else
        int_stat_r <= int_stat_r | events;
    end
  end

  // level output, high while any unmasked status bit is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |((int_stat_r | events) & int_mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power modes: idle drops to sleep, host asks for deeper, current flow wakes
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      capacity_warning_pkg::MODE_NORMAL:
        if (cell_idle && config_r[capacity_warning_pkg::BIT_AUTO_SLEEP])
          mode_nxt = capacity_warning_pkg::MODE_SLEEP; // [R9]
      capacity_warning_pkg::MODE_SLEEP:
        if (!cell_idle)
          mode_nxt = capacity_warning_pkg::MODE_NORMAL;
        else if (req_r[capacity_warning_pkg::BIT_REQ_LOWEST])
          mode_nxt = capacity_warning_pkg::MODE_LOWEST_POWER; // [R9]
        else if (req_r[capacity_warning_pkg::BIT_REQ_DEEP])
          mode_nxt = capacity_warning_pkg::MODE_DEEP_SLEEP; // [R9]
      capacity_warning_pkg::MODE_DEEP_SLEEP:
        if (!cell_idle)
          mode_nxt = capacity_warning_pkg::MODE_NORMAL;
        else if (req_r[capacity_warning_pkg::BIT_REQ_LOWEST])
          mode_nxt = capacity_warning_pkg::MODE_LOWEST_POWER;
      capacity_warning_pkg::MODE_LOWEST_POWER:
        if (!cell_idle)
          mode_nxt = capacity_warning_pkg::MODE_NORMAL;
      default: mode_nxt = capacity_warning_pkg::MODE_NORMAL;
    endcase
  end

  // mode register and host requests; a request ends when granted or on wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= capacity_warning_pkg::MODE_NORMAL;
      req_r <= 2'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      if (wr_en && paddr == capacity_warning_pkg::OFF_MODE_REQ)
        req_r <= req_r | pwdata[1:0]; // [R9]
      else if (mode_nxt == capacity_warning_pkg::MODE_NORMAL
               && mode_r != capacity_warning_pkg::MODE_NORMAL)
        req_r <= 2'h0;
      else if (mode_nxt == capacity_warning_pkg::MODE_LOWEST_POWER)
        req_r <= 2'h0;
      else if (mode_nxt == capacity_warning_pkg::MODE_DEEP_SLEEP)
        req_r[capacity_warning_pkg::BIT_REQ_DEEP] <= 1'b0;
    end
  end

  // outputs straight from flops
  assign low_charge_warning_flag = low_r;
  assign final_discharge_warning_flag = final_r;
  assign internal_short_flag = short_r;
  assign tab_disconnect_flag = tab_r;
  assign power_mode = mode_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cap_below_early;
    capacity_valid && below(capacity_in, ew_set_r);
  endsequence
  sequence cap_holds_early;
    capacity_valid && !below(ew_clr_r, capacity_in);
  endsequence
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_access_s;
    psel && penable;
  endsequence

  low_set_a: assert property (cap_below_early |=> low_charge_warning_flag) // [R1]
    else $error("low-charge warning not set below early level");
  low_hold_a: assert property (low_r ##0 cap_holds_early |=> low_r) // [R2]
    else $error("low-charge warning cleared without passing clear level");
  final_set_a: assert property (capacity_valid && fw_set_r != MINUS_ONE // [R3]
      && below(capacity_in, fw_set_r) |=> final_discharge_warning_flag)
    else $error("final warning not set below final level");
  final_off_a: assert property (!final_r && fw_set_r == MINUS_ONE |=> !final_r) // [R4]
    else $error("final warning raised while disabled");
  final_clear_a: assert property (final_r && capacity_valid // [R5]
      && !(fw_set_r != MINUS_ONE && below(capacity_in, fw_set_r))
      && below(fw_clr_r, capacity_in) |=> !final_r)
    else $error("final warning not cleared above clear level");
  short_set_a: assert property (cell_relaxed && short_detected // [R6]
      |=> internal_short_flag)
    else $error("internal short not flagged");
  tab_set_a: assert property (config_r[capacity_warning_pkg::BIT_PARALLEL] // [R7]
      && tab_loss_detected |=> tab_r [*1])
    else $error("tab disconnect not flagged");
  mode_wake_a: assert property (mode_r != capacity_warning_pkg::MODE_NORMAL // [R9]
      && !cell_idle |=> power_mode == capacity_warning_pkg::MODE_NORMAL)
    else $error("no wake to normal on current flow");
  apb_read_a: assert property (apb_setup_s ##0 // [R10]
      (!pwrite && paddr == capacity_warning_pkg::OFF_CAPACITY)
      ##1 apb_access_s |-> pready && prdata[CAP_W-1:0] == $past(capacity_r))
    else $error("capacity read back wrong");
endmodule : capacity_warning_flags

// ---- rtl/capacity_warning_pkg.sv ----
// constants for the capacity warning flag block
package capacity_warning_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CAPACITY = 8'h04;
  localparam logic [7:0] OFF_EW_SET = 8'h08;
  localparam logic [7:0] OFF_EW_CLR = 8'h0C;
  localparam logic [7:0] OFF_FW_SET = 8'h10;
  localparam logic [7:0] OFF_FW_CLR = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;
  localparam logic [7:0] OFF_MODE_REQ = 8'h1C;
  localparam logic [7:0] OFF_INT_STAT = 8'h20;
  localparam logic [7:0] OFF_INT_MASK = 8'h24;
  localparam logic [7:0] OFF_BLOCK_A = 8'h40;
  localparam logic [7:0] OFF_BLOCK_B = 8'h60;
  // scratch storage shape: two blocks of 32 bytes
  localparam int BLOCK_BYTES = 32;
  localparam int BLOCK_WORDS = BLOCK_BYTES / 4;
  // status and interrupt bit positions
  localparam int BIT_LOW = 0;
  localparam int BIT_FINAL = 1;
  localparam int BIT_SHORT = 2;
  localparam int BIT_TAB = 3;
  localparam int BIT_MODE_LSB = 4;
  // config and mode request bit positions
  localparam int BIT_PARALLEL = 0;
  localparam int BIT_AUTO_SLEEP = 1;
  localparam int BIT_REQ_DEEP = 0;
  localparam int BIT_REQ_LOWEST = 1;
  // reset values of the programmable levels, in mAh, and of config and interrupt mask
  localparam logic [15:0] RST_EW_SET = 16'h0000;
  localparam logic [15:0] RST_EW_CLR = 16'h0000;
  localparam logic [15:0] RST_FW_SET = 16'hFFFF;
  localparam logic [15:0] RST_FW_CLR = 16'h0000;
  localparam logic [1:0] RST_CONFIG = 2'h2;
  localparam logic [3:0] RST_INT_MASK = 4'h0;
  // power modes, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_SLEEP = 4'h2,
    MODE_DEEP_SLEEP = 4'h4,
    MODE_LOWEST_POWER = 4'h8
  } power_mode_t;
endpackage : capacity_warning_pkg

// ---- tb/host_model.sv ----
// host-side apb master that issues register and storage commands
`timescale 1ns/10ps
module host_model (
  input wire logic pclk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  // bus idles deselected from time zero
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    hung = 1'b0;
  end

  ////////////////////////////////////////
  // one setup plus access; request held until pready is seen, flagged hung after 20 cycles
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a; // block and byte offset pick the location
    pwrite <= wr;
    pwdata <= wr ? wd : ~pwdata; // unused data keeps moving on reads
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hung <= 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_model

// ---- tb/testbench.sv ----
// self-checking bench for the capacity warning flag block
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] cap_in;
  logic cap_valid, relaxed, short_det, tab_loss, idle;
  logic low_f, final_f, short_f, tab_f, irq;
  logic [3:0] power_mode;
  int err_count = 0;
  int checks = 0;

  capacity_warning_flags dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capacity_in(cap_in), .capacity_valid(cap_valid),
    .cell_relaxed(relaxed), .short_detected(short_det), .tab_loss_detected(tab_loss),
    .cell_idle(idle), .low_charge_warning_flag(low_f),
    .final_discharge_warning_flag(final_f), .internal_short_flag(short_f),
    .tab_disconnect_flag(tab_f), .power_mode(power_mode), .irq(irq));
  host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hung(hung));

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // a bus that never answers ends the run
  always @(posedge pclk)
    if (hung === 1'b1)
    begin
      err_count++;
      summarize();
    end

  ////////////////////////////////////////
  // compares and bus helpers
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask : chk_flag

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr

  // read data and error response both judged
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk_word(exp, r);
    chk_flag(eexp, e);
  endtask : rdc

  // one-cycle capacity strobe, looked at once it has landed
  task automatic cap(input logic [15:0] v);
    @(posedge pclk);
    cap_in <= v;
    cap_valid <= 1'b1;
    @(posedge pclk);
    cap_valid <= 1'b0;
    @(negedge pclk);
  endtask : cap

  task automatic wait_mode(input logic [3:0] exp);
    int n;
    n = 0;
    while (power_mode !== exp && n < 10)
    begin
      @(negedge pclk);
      n++;
    end
    chk_word({28'h0, exp}, {28'h0, power_mode});
  endtask : wait_mode

  ////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rdc(capacity_warning_pkg::OFF_FW_SET, 32'h0000FFFF, 1'b0);
    rdc(capacity_warning_pkg::OFF_CONFIG, 32'h00000002, 1'b0);
    rdc(capacity_warning_pkg::OFF_INT_MASK, 32'h00000000, 1'b0);
    cap(16'hFFF0);
    chk_flag(1'b0, final_f);
    chk_flag(1'b1, low_f); // minus sixteen is below a zero level
  endtask : t_reset

  // hysteresis: set strictly below 100, clear strictly above 200
  task automatic t_early();
    wr(capacity_warning_pkg::OFF_EW_SET, 32'h64);
    wr(capacity_warning_pkg::OFF_EW_CLR, 32'hC8);
    cap(16'h00C9);
    chk_flag(1'b0, low_f); // flag left set by reset scenario clears
    cap(16'h0096);
    chk_flag(1'b0, low_f);
    cap(16'h0064);
    chk_flag(1'b0, low_f);
    cap(16'h0063);
    chk_flag(1'b1, low_f);
    cap(16'h0096);
    chk_flag(1'b1, low_f);
    cap(16'h00C8);
    chk_flag(1'b1, low_f);
    cap(16'h00C9);
    chk_flag(1'b0, low_f);
    rdc(capacity_warning_pkg::OFF_CAPACITY, 32'hC9, 1'b0);
  endtask : t_early

  task automatic t_final();
    wr(capacity_warning_pkg::OFF_FW_SET, 32'h32);
    wr(capacity_warning_pkg::OFF_FW_CLR, 32'h50);
    cap(16'h0031);
    chk_flag(1'b1, final_f);
    cap(16'h0050);
    chk_flag(1'b1, final_f);
    cap(16'h0051);
    chk_flag(1'b0, final_f);
    cap(16'hFFF0);
    chk_flag(1'b1, final_f); // negative capacity seen as signed
  endtask : t_final

  // short needs a relaxed cell; irq follows the mask
  task automatic t_short();
    @(posedge pclk);
    short_det <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_flag(1'b0, short_f);
    relaxed <= 1'b1;
    repeat (3) @(negedge pclk);
    chk_flag(1'b1, short_f);
    chk_flag(1'b0, irq); // masked
    @(posedge pclk);
    short_det <= 1'b0;
    wr(capacity_warning_pkg::OFF_INT_MASK, 32'h4);
    repeat (2) @(negedge pclk);
    chk_flag(1'b1, irq);
    rdc(capacity_warning_pkg::OFF_STATUS, 32'h17, 1'b0);
    rdc(capacity_warning_pkg::OFF_INT_STAT, 32'h7, 1'b0);
    wr(capacity_warning_pkg::OFF_INT_STAT, 32'h4);
    wr(capacity_warning_pkg::OFF_STATUS, 32'h4);
    repeat (2) @(negedge pclk);
    chk_flag(1'b0, irq);
    chk_flag(1'b0, short_f);
  endtask : t_short

  task automatic t_tab();
    @(posedge pclk);
    tab_loss <= 1'b1;
    repeat (3) @(negedge pclk);
    chk_flag(1'b0, tab_f); // single cell pack ignores it
    wr(capacity_warning_pkg::OFF_CONFIG, 32'h3);
    repeat (2) @(negedge pclk);
    chk_flag(1'b1, tab_f);
    @(posedge pclk);
    tab_loss <= 1'b0;
  endtask : t_tab

  task automatic t_store();
    wr(capacity_warning_pkg::OFF_BLOCK_A, 32'hA5A50001);
    wr(capacity_warning_pkg::OFF_BLOCK_B, 32'h5A5A0002);
    wr(8'h5C, 32'h12345678);
    rdc(capacity_warning_pkg::OFF_BLOCK_A, 32'hA5A50001, 1'b0);
    rdc(capacity_warning_pkg::OFF_BLOCK_B, 32'h5A5A0002, 1'b0);
    rdc(8'h5C, 32'h12345678, 1'b0);
    rdc(8'h30, 32'h00000000, 1'b1); // unmapped
  endtask : t_store

  task automatic t_mode();
    idle <= 1'b1;
    wait_mode(capacity_warning_pkg::MODE_SLEEP);
    wr(capacity_warning_pkg::OFF_MODE_REQ, 32'h1);
    wait_mode(capacity_warning_pkg::MODE_DEEP_SLEEP);
    wr(capacity_warning_pkg::OFF_MODE_REQ, 32'h2);
    wait_mode(capacity_warning_pkg::MODE_LOWEST_POWER);
    @(posedge pclk);
    idle <= 1'b0;
    wait_mode(capacity_warning_pkg::MODE_NORMAL);
  endtask : t_mode

  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    presetn = 1'b0;
    cap_in = 16'h0000;
    cap_valid = 1'b0;
    relaxed = 1'b0;
    short_det = 1'b0;
    tab_loss = 1'b0;
    idle = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_early();
    t_final();
    t_short();
    t_tab();
    t_store();
    t_mode();
    summarize();
  end
endmodule : testbench
